// ### src/uirp_pkg.sv
// constants and types for the indirect register port
// assumes an 8-bit special-function-register bus and a byte-wide core register set
package uirp_pkg;

    // special-function-register offsets
    localparam logic [7:0] UIRP_SFR_ADDR_CTRL = 8'h96;
    localparam logic [7:0] UIRP_SFR_ADDR_DATA = 8'h97;

    // address/control register fields
    localparam int UIRP_BUSY_BIT = 7;
    localparam int UIRP_AUTO_BIT = 6;
    localparam int UIRP_ADDR_MSB = 5;

    // values after reset
    localparam logic [5:0] UIRP_ADDR_RESET = 6'h00;
    localparam logic UIRP_AUTO_RESET = 1'b0;
    localparam logic [7:0] UIRP_DATA_RESET = 8'h00;
    localparam logic [3:0] UIRP_INDEX_RESET = 4'h0;

    // core addresses: interrupt flags and enables
    localparam logic [5:0] UIRP_CA_IN_FLAGS = 6'h02;
    localparam logic [5:0] UIRP_CA_OUT_FLAGS = 6'h04;
    localparam logic [5:0] UIRP_CA_COMMON_FLAGS = 6'h06;
    localparam logic [5:0] UIRP_CA_IN_ENABLES = 6'h07;
    localparam logic [5:0] UIRP_CA_OUT_ENABLES = 6'h09;
    localparam logic [5:0] UIRP_CA_COMMON_ENABLES = 6'h0B;
    // core addresses: common registers
    localparam logic [5:0] UIRP_CA_FUNC_ADDR = 6'h00;
    localparam logic [5:0] UIRP_CA_POWER = 6'h01;
    localparam logic [5:0] UIRP_CA_FRAME_LOW = 6'h0C;
    localparam logic [5:0] UIRP_CA_FRAME_HIGH = 6'h0D;
    localparam logic [5:0] UIRP_CA_INDEX = 6'h0E;
    localparam logic [5:0] UIRP_CA_CLOCK_RECOVERY = 6'h0F;
    localparam logic [5:0] UIRP_CA_EP_ENABLE = 6'h1E;
    localparam logic [5:0] UIRP_CA_FIFO_FIRST = 6'h20;
    localparam logic [5:0] UIRP_CA_FIFO_LAST = 6'h22;
    // core addresses: indexed registers
    localparam logic [5:0] UIRP_CA_IN_CSR_LOW = 6'h11;
    localparam logic [5:0] UIRP_CA_IN_CSR_HIGH = 6'h12;
    localparam logic [5:0] UIRP_CA_OUT_CSR_LOW = 6'h14;
    localparam logic [5:0] UIRP_CA_OUT_CSR_HIGH = 6'h15;
    localparam logic [5:0] UIRP_CA_OUT_COUNT_LOW = 6'h16;
    localparam logic [5:0] UIRP_CA_OUT_COUNT_HIGH = 6'h17;

    // endpoint select codes
    localparam logic [3:0] UIRP_EP_ZERO = 4'h0;
    localparam logic [3:0] UIRP_EP_ONE = 4'h1;
    localparam logic [3:0] UIRP_EP_TWO = 4'h2;

    typedef enum logic [2:0] {
        UIRP_TGT_NONE,
        UIRP_TGT_DIRECT,
        UIRP_TGT_FIFO,
        UIRP_TGT_INDEXED,
        UIRP_TGT_INDEX
    } uirp_target_t;

    typedef enum logic [1:0] {
        UIRP_IDLE,
        UIRP_READ,
        UIRP_WRITE
    } uirp_state_t;

endpackage

// ### src/uirp_port.sv
// indirect register port: two special-function registers reaching the usb core registers
// assumes single-cycle sfr read/write strobes and a core that answers each access with core_ack
//
// Contract
// - data register accesses go to the core register at the six-bit target address.
// - writing one to busy starts a core read; writing zero does nothing.
// - busy reads one during a core access, zero once data is valid.
// - with auto-read set, each data register read launches the next read, same address.
// - address load and busy set in one write start the read at the new address.
// - in, out and common event flags decode at 0x02, 0x04, 0x06.
// - in, out and common event enables decode at 0x07, 0x09, 0x0B.
// - function address, power, frame low at 0x00, 0x01, 0x0C; frame high follows.
// - endpoint index, clock recovery, endpoint enable decode at 0x0E, 0x0F, 0x1E.
// - indexed in high, out low, out high status at 0x12, 0x14, 0x15.
// - endpoint-zero status shares 0x11, byte count shares 0x16; count high at 0x17.
// - indexed registers act on the endpoint last written to the index register.
// - endpoint select codes 0000, 0001, 0010 pick endpoints; higher codes reserved.
`timescale 1ns/10ps
`default_nettype none

module uirp_port
    import uirp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic core_rd,
    output logic core_wr,
    output logic [5:0] core_addr,
    output logic [7:0] core_wdata,
    output logic [1:0] core_ep,
    output logic core_fifo,
    input wire logic [7:0] core_rdata,
    input wire logic core_ack
);

    uirp_state_t state_reg;
    uirp_state_t state_next;
    logic [5:0] addr_reg;
    logic [5:0] addr_next;
    logic auto_reg;
    logic auto_next;
    logic [7:0] data_reg;
    logic [7:0] data_next;
    logic [3:0] index_reg;
    logic [3:0] index_next;
    logic [5:0] acc_addr_reg;
    logic [5:0] acc_addr_next;
    logic [7:0] acc_wdata_reg;
    logic [7:0] acc_wdata_next;
    uirp_target_t acc_tgt_reg;
    uirp_target_t acc_tgt_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    logic busy;
    logic ctrl_wr;
    logic data_wr;
    logic data_rd;
    logic core_side;
    logic start_read;
    logic start_write;
    logic start_auto;

    // classify a core address against the current endpoint select
    // reserved selects and registers that endpoint zero lacks fall to none
    function automatic uirp_target_t uirp_decode(input logic [5:0] ca, input logic [3:0] endpoint_select_field);
        uirp_target_t t;
        logic ep_valid;
        logic ep_zero;
        t = UIRP_TGT_NONE;
        ep_valid = (endpoint_select_field == UIRP_EP_ZERO) || (endpoint_select_field == UIRP_EP_ONE) || (endpoint_select_field == UIRP_EP_TWO);
        ep_zero = (endpoint_select_field == UIRP_EP_ZERO);
        case (ca)
            UIRP_CA_IN_FLAGS, UIRP_CA_OUT_FLAGS, UIRP_CA_COMMON_FLAGS,
            UIRP_CA_IN_ENABLES, UIRP_CA_OUT_ENABLES, UIRP_CA_COMMON_ENABLES,
            UIRP_CA_FUNC_ADDR, UIRP_CA_POWER, UIRP_CA_FRAME_LOW, UIRP_CA_FRAME_HIGH,
            UIRP_CA_CLOCK_RECOVERY, UIRP_CA_EP_ENABLE: t = UIRP_TGT_DIRECT;
            UIRP_CA_INDEX: t = UIRP_TGT_INDEX;
            // endpoint zero only has its control/status and byte count
            UIRP_CA_IN_CSR_LOW, UIRP_CA_OUT_COUNT_LOW: t = ep_valid ? UIRP_TGT_INDEXED : UIRP_TGT_NONE;
            UIRP_CA_IN_CSR_HIGH, UIRP_CA_OUT_CSR_LOW, UIRP_CA_OUT_CSR_HIGH,
            UIRP_CA_OUT_COUNT_HIGH: t = (ep_valid && !ep_zero) ? UIRP_TGT_INDEXED : UIRP_TGT_NONE;
            default: t = (ca >= UIRP_CA_FIFO_FIRST && ca <= UIRP_CA_FIFO_LAST) ? UIRP_TGT_FIFO : UIRP_TGT_NONE;
        endcase
        return t;
    endfunction

    // busy covers every access, local ones included, so polling is uniform
    assign busy = (state_reg != UIRP_IDLE);
    assign ctrl_wr = sfr_wr && (sfr_addr == UIRP_SFR_ADDR_CTRL);
    assign data_wr = sfr_wr && (sfr_addr == UIRP_SFR_ADDR_DATA);
    assign data_rd = sfr_rd && (sfr_addr == UIRP_SFR_ADDR_DATA);
    // launch requests; only taken while idle, so one arriving while busy is dropped, not queued
    assign start_read = ctrl_wr && sfr_wdata[UIRP_BUSY_BIT];
    assign start_write = data_wr;
    assign start_auto = data_rd && auto_reg;
    assign core_side = (acc_tgt_reg == UIRP_TGT_DIRECT) || (acc_tgt_reg == UIRP_TGT_FIFO)
        || (acc_tgt_reg == UIRP_TGT_INDEXED);

    // core strobes hold until the core acknowledges
    assign core_rd = (state_reg == UIRP_READ) && core_side;
    assign core_wr = (state_reg == UIRP_WRITE) && core_side;
    assign core_addr = acc_addr_reg;
    assign core_wdata = acc_wdata_reg;
    assign core_ep = index_reg[1:0];
    assign core_fifo = (acc_tgt_reg == UIRP_TGT_FIFO);
    assign sfr_rdata = rdata_reg;

    // access sequencing and software-visible register updates
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        auto_next = auto_reg;
        data_next = data_reg;
        index_next = index_reg;
        acc_addr_next = acc_addr_reg;
        acc_wdata_next = acc_wdata_reg;
        acc_tgt_next = acc_tgt_reg;
        // address and auto-read may change any time; the access in flight keeps its own copy
        if (ctrl_wr) begin
            addr_next = sfr_wdata[UIRP_ADDR_MSB:0];
            auto_next = sfr_wdata[UIRP_AUTO_BIT];
        end
        unique case (state_reg)
            UIRP_IDLE: begin
                if (start_read) begin
                    // start at the newly written address, not the old one
                    state_next = UIRP_READ;
                    acc_addr_next = sfr_wdata[UIRP_ADDR_MSB:0];
                    acc_tgt_next = uirp_decode(sfr_wdata[UIRP_ADDR_MSB:0], index_reg);
                end else if (start_write) begin
                    state_next = UIRP_WRITE;
                    acc_addr_next = addr_reg;
                    acc_wdata_next = sfr_wdata;
                    acc_tgt_next = uirp_decode(addr_reg, index_reg);
                end else if (start_auto) begin
                    // streaming reads keep the target address untouched
                    state_next = UIRP_READ;
                    acc_addr_next = addr_reg;
                    acc_tgt_next = uirp_decode(addr_reg, index_reg);
                end
            end
            UIRP_READ: begin
                if (acc_tgt_reg == UIRP_TGT_NONE) begin
                    data_next = UIRP_DATA_RESET;
                    state_next = UIRP_IDLE;
                end else if (acc_tgt_reg == UIRP_TGT_INDEX) begin
                    data_next = {4'h0, index_reg};
                    state_next = UIRP_IDLE;
                end else if (core_ack) begin
                    data_next = core_rdata;
                    state_next = UIRP_IDLE;
                end
            end
            UIRP_WRITE: begin
                if (acc_tgt_reg == UIRP_TGT_INDEX) begin
                    index_next = acc_wdata_reg[3:0];
                    state_next = UIRP_IDLE;
                end else if (acc_tgt_reg == UIRP_TGT_NONE || core_ack) begin
                    state_next = UIRP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= UIRP_IDLE;
            addr_reg <= UIRP_ADDR_RESET;
            auto_reg <= UIRP_AUTO_RESET;
            data_reg <= UIRP_DATA_RESET;
            index_reg <= UIRP_INDEX_RESET;
            acc_addr_reg <= UIRP_ADDR_RESET;
            acc_wdata_reg <= UIRP_DATA_RESET;
            acc_tgt_reg <= UIRP_TGT_NONE;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            auto_reg <= auto_next;
            data_reg <= data_next;
            index_reg <= index_next;
            acc_addr_reg <= acc_addr_next;
            acc_wdata_reg <= acc_wdata_next;
            acc_tgt_reg <= acc_tgt_next;
        end
    end

    // sfr read data is registered; it appears the cycle after the read strobe
    always_comb begin
        rdata_next = rdata_reg;
        if (sfr_rd) begin
            if (sfr_addr == UIRP_SFR_ADDR_CTRL) begin
                rdata_next = {busy, auto_reg, addr_reg};
            end else if (sfr_addr == UIRP_SFR_ADDR_DATA) begin
                rdata_next = data_reg;
            end else begin
                rdata_next = UIRP_DATA_RESET;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= UIRP_DATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

endmodule

`default_nettype wire

// ### tb/uirp_core_model.sv
// behavioural usb core register set answering core_rd/core_wr
// assumes one request at a time; lat sets the answer delay
`timescale 1ns/10ps
`default_nettype none
module uirp_core_model (
    input wire logic sys_clk,
    input wire logic core_rd,
    input wire logic core_wr,
    input wire logic [5:0] core_addr,
    input wire logic [7:0] core_wdata,
    input wire logic [1:0] core_ep,
    input wire logic [3:0] lat,
    output logic [7:0] core_rdata,
    output logic core_ack
);
    logic [7:0] mem [256];
    logic [3:0] cnt;
    initial begin
        core_ack = 1'b0;
        core_rdata = 8'h00;
        cnt = 4'h0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    end
    // data lines wander between answers so a late sample shows
    always @(posedge sys_clk) begin
        core_ack <= 1'b0;
        core_rdata <= ~core_rdata;
        if ((core_rd || core_wr) && !core_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt >= lat) begin
                core_ack <= 1'b1;
                cnt <= 4'h0;
                if (core_rd) core_rdata <= mem[{core_ep, core_addr}];
                if (core_wr) mem[{core_ep, core_addr}] <= core_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/uirp_port_props.sv
// port checker for the indirect register port
// assumes it is bound into every uirp_port instance
`timescale 1ns/10ps
`default_nettype none
module uirp_port_props
    import uirp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic core_rd,
    input wire logic core_wr,
    input wire logic [5:0] core_addr,
    input wire logic [7:0] core_wdata,
    input wire logic [1:0] core_ep,
    input wire logic core_fifo,
    input wire logic [7:0] core_rdata,
    input wire logic core_ack
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire logic req = core_rd | core_wr;
    wire logic ctl_w = sfr_wr && sfr_addr == UIRP_SFR_ADDR_CTRL;
    property p_rd_hold; core_rd && !core_ack |=> core_rd && $stable(core_addr); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read request moved early");
    property p_wr_hold; core_wr && !core_ack |=> core_wr && $stable({core_addr, core_wdata}); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write request moved early");
    property p_drop; req && core_ack |=> !req; endproperty
    a_drop: assert property (p_drop) else $error("request held past answer");
    property p_one; !(core_rd && core_wr); endproperty
    a_one: assert property (p_one) else $error("read and write together");
    property p_start; ctl_w && sfr_wdata[7] && sfr_wdata[5:1] == 5'h00 && !req
        |=> core_rd && core_addr == $past(sfr_wdata[5:0]); endproperty
    a_start: assert property (p_start) else $error("busy write gave no read");
    property p_zero; ctl_w && !sfr_wdata[7] && !req |=> !core_rd; endproperty
    a_zero: assert property (p_zero) else $error("zero busy started a read");
    property p_map; req |-> core_addr inside {[6'h00:6'h02], 6'h04, 6'h06, 6'h07, 6'h09, [6'h0B:6'h0D],
        6'h0F, 6'h11, 6'h12, [6'h14:6'h17], 6'h1E, [6'h20:6'h22]}; endproperty
    a_map: assert property (p_map) else $error("strobe to unmapped address");
    property p_busy; sfr_rd && sfr_addr == UIRP_SFR_ADDR_CTRL && req && !core_ack |=> sfr_rdata[7]; endproperty
    a_busy: assert property (p_busy) else $error("busy low during access");
    property p_fifo; req |-> core_fifo == (core_addr inside {[6'h20:6'h22]}); endproperty
    a_fifo: assert property (p_fifo) else $error("fifo flag disagrees with address");
    c_rd: cover property (core_rd && core_ack);
    c_wr: cover property (core_wr && core_ack);
    c_busy: cover property (sfr_rd && sfr_addr == UIRP_SFR_ADDR_CTRL && req);
endmodule
bind uirp_port uirp_port_props props_u (.sys_clk, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .core_rd, .core_wr, .core_addr, .core_wdata, .core_ep, .core_fifo, .core_rdata, .core_ack);
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the indirect register port with a core model
// assumes package, port, core model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
    import uirp_pkg::*;
    logic sys_clk, nrst, sfr_wr, sfr_rd, core_rd, core_wr, core_fifo, core_ack;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, core_wdata, core_rdata, rd;
    logic [5:0] core_addr;
    logic [1:0] core_ep, ep;
    logic [3:0] lat;
    int n_fail, total_checks, cyc;
    uirp_port dut_u (.sys_clk, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .core_rd, .core_wr,
        .core_addr, .core_wdata, .core_ep, .core_fifo, .core_rdata, .core_ack);
    uirp_core_model core_u (.sys_clk, .core_rd, .core_wr, .core_addr, .core_wdata, .core_ep, .lat, .core_rdata,
        .core_ack);
    task automatic give_verdict();
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobes launched on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        rd = sfr_rdata;
    endtask
    // bounded wait for busy to clear
    task automatic poll();
        for (int k = 0; k < 40; k++) begin
            rdr(UIRP_SFR_ADDR_CTRL);
            if (rd[7] === 1'b0) break;
        end
        chk(8'(rd[7]), 8'h00);
    endtask
    function automatic logic [7:0] pat(input logic [5:0] a);
        return {ep, a} ^ 8'hA5;
    endfunction
    task automatic rcore(input logic [5:0] a, input logic [7:0] exp);
        wr(UIRP_SFR_ADDR_CTRL, {2'b10, a});
        poll();
        rdr(UIRP_SFR_ADDR_DATA);
        chk(rd, exp);
    endtask
    task automatic setidx(input logic [7:0] v);
        wr(UIRP_SFR_ADDR_CTRL, 8'h0E);
        poll();
        wr(UIRP_SFR_ADDR_DATA, v);
        poll();
        ep = v[1:0];
    endtask
    task automatic t_reset();
        rdr(UIRP_SFR_ADDR_CTRL);
        chk(rd, 8'h00);
        rdr(UIRP_SFR_ADDR_DATA);
        chk(rd, 8'h00);
    endtask
    task automatic t_decode();
        logic [5:0] m [15] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h06, 6'h07, 6'h09, 6'h0B, 6'h0C, 6'h0D, 6'h0F,
            6'h1E, 6'h20, 6'h21, 6'h22};
        foreach (m[i]) rcore(m[i], pat(m[i]));
        wr(UIRP_SFR_ADDR_CTRL, 8'h81);
        rdr(UIRP_SFR_ADDR_CTRL);
        chk(8'(rd[7]), 8'h01);
        poll();
        wr(UIRP_SFR_ADDR_CTRL, 8'h02);
        rdr(UIRP_SFR_ADDR_CTRL);
        chk(rd, 8'h02);
    endtask
    task automatic t_write();
        lat = 4'h4;
        wr(UIRP_SFR_ADDR_CTRL, 8'h00);
        wr(UIRP_SFR_ADDR_DATA, 8'h5A);
        rdr(UIRP_SFR_ADDR_CTRL);
        chk(8'(rd[7]), 8'h01);
        poll();
        wr(UIRP_SFR_ADDR_DATA, 8'h3C);
        poll();
        rcore(6'h00, 8'h3C);
        wr(UIRP_SFR_ADDR_CTRL, 8'h3F);
        wr(UIRP_SFR_ADDR_DATA, 8'hFF);
        poll();
        rcore(6'h3F, 8'h00);
        rcore(6'h00, 8'h3C);
    endtask
    task automatic t_index();
        setidx(8'h02);
        rcore(6'h12, pat(6'h12));
        rcore(6'h15, pat(6'h15));
        rcore(6'h17, pat(6'h17));
        setidx(8'h00);
        rcore(6'h12, 8'h00);
        rcore(6'h16, pat(6'h16));
        setidx(8'h03);
        rcore(6'h11, 8'h00);
        rcore(6'h0E, 8'h03);
        setidx(8'h00);
    endtask
    task automatic t_auto();
        lat = 4'h0;
        wr(UIRP_SFR_ADDR_CTRL, 8'hE1);
        poll();
        rdr(UIRP_SFR_ADDR_DATA);
        chk(rd, pat(6'h21));
        rdr(UIRP_SFR_ADDR_CTRL);
        chk(rd, 8'hE1);
        poll();
        rdr(UIRP_SFR_ADDR_CTRL);
        chk(rd, 8'h61);
        wr(UIRP_SFR_ADDR_CTRL, 8'h21);
    endtask
    // reset in mid-run, with index, auto-read and address all away from their reset values
    task automatic t_rerun();
        setidx(8'h01);
        wr(UIRP_SFR_ADDR_CTRL, 8'h4E);
        @(negedge sys_clk);
        nrst = 1'b0;
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        ep = 2'b00;
        t_reset();
        rcore(6'h0E, 8'h00);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        {nrst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, ep} = '0;
        lat = 4'h2;
        repeat (10) @(negedge sys_clk);
        nrst = 1'b1;
        t_reset();
        t_decode();
        t_write();
        t_index();
        t_auto();
        t_rerun();
        give_verdict();
    end
endmodule
`default_nettype wire
